// ===== bench/rs485_serial_port_uart_control_bench.sv
/* Bench for the serial port: register window, both directions of
   traffic. Assumes the remote model runs at divisor one. */
`default_nettype none
module rs485_serial_port_uart_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] address = 3'h0;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic [7:0] write_data = 8'h00;
    logic auto_direction = 1'b0;
    logic [7:0] read_data;
    logic tx_line, rx_line, driver_enable, request_to_send, interrupt_request, t;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int q[$];
    always #2.5 clock = ~clock;
    rsu_serial_port i_dut (.clock(clock), .reset_n(reset_n), .address(address),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .write_data(write_data),
        .read_data(read_data), .rx_line(rx_line), .tx_line(tx_line), .driver_enable(driver_enable),
        .request_to_send(request_to_send), .interrupt_request(interrupt_request),
        .auto_direction(auto_direction));
    rsu_remote i_far (.tx_line(tx_line), .rx_line(rx_line));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clock);
        address = a;
        write_data = d;
        write_strobe = 1'b1;
        @(negedge clock);
        write_strobe = 1'b0;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        @(negedge clock);
        address = a;
        read_strobe = 1'b1;
        @(negedge clock);
        read_strobe = 1'b0;
        chk(read_data, exp);
    endtask
    // Checks direction pins 20 cycles into the start bit, then the decoded byte
    task automatic tx_byte(input logic [7:0] b, input logic [7:0] dir);
        t = i_far.got_valid;
        wr(3'h0, b);
        repeat (20) @(negedge clock);
        chk({6'h0, request_to_send, driver_enable}, dir);
        for (int i = 0; i < 25000 && i_far.got_valid === t; i++) @(negedge clock);
        chk({7'h0, i_far.got_valid !== t}, 8'h01);
        chk(i_far.got, b);
        repeat (1200) @(negedge clock);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Ceiling well above the four frames' worth of cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h0336be04));
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        rc(3'h3, 8'h00);
        rc(3'h4, 8'h00);
        rc(3'h5, 8'h60);
        rc(3'h2, 8'h01);
        rc(3'h7, 8'h00);
        wr(3'h3, 8'h80);
        rc(3'h0, 8'h0c);
        wr(3'h0, 8'h01);
        rc(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        rc(3'h1, 8'h00);
        rc(3'h3, 8'h03);
        rc(3'h0, 8'h00);
        rc(3'h0, 8'h00);
        rc(3'h5, 8'h60);
        $display("test registers end");
        wr(3'h4, 8'h02);
        rc(3'h5, 8'h60);
        tx_byte(8'($urandom), 8'h03);
        wr(3'h4, 8'h00);
        chk({6'h0, request_to_send, driver_enable}, 8'h00);
        $display("test manual end");
        auto_direction = 1'b1;
        wr(3'h4, 8'h02);
        repeat (3) @(negedge clock);
        chk({6'h0, request_to_send, driver_enable}, 8'h02);
        wr(3'h4, 8'h00);
        wr(3'h3, 8'h06);
        // Seven bits, two stops: the far end reads the first stop as bit 7
        tx_byte({1'b1, 7'($urandom)}, 8'h01);
        chk({6'h0, request_to_send, driver_enable}, 8'h00);
        wr(3'h3, 8'h03);
        $display("test auto end");
        repeat (2) begin
            q.push_back($urandom % 256);
            i_far.send(8'(q[$]));
        end
        repeat (4) @(negedge clock);
        chk({7'h0, interrupt_request}, 8'h00);
        wr(3'h4, 8'h08);
        chk({7'h0, interrupt_request}, 8'h01);
        rc(3'h5, 8'h61);
        rc(3'h2, 8'h04);
        while (q.size() > 0) rc(3'h0, 8'(q.pop_front()));
        rc(3'h5, 8'h60);
        rc(3'h2, 8'h01);
        chk({7'h0, interrupt_request}, 8'h00);
        wr(3'h3, 8'h43);
        chk({7'h0, tx_line}, 8'h00);
        wr(3'h3, 8'h03);
        chk({7'h0, tx_line}, 8'h01);
        $display("test receive end");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== bench/rsu_remote.sv
/* Remote serial device on the line pair: sends and decodes 8N1 frames.
   Assumes the port runs at 115200 bit/s with an idle-high line. */
`default_nettype none
module rsu_remote (
    input wire logic tx_line,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime BIT_NS = 8680.6;
    logic [7:0] got = 8'h00;
    logic got_valid = 1'b0;
    initial rx_line = 1'b1;
    task automatic send(input logic [7:0] b);
        rx_line = 1'b0;
        #BIT_NS;
        for (int i = 0; i < 8; i++) begin
            rx_line = b[i];
            #BIT_NS;
        end
        rx_line = 1'b1;
        #BIT_NS;
    endtask
    // Samples mid-bit; toggles got_valid at mid stop
    always @(negedge tx_line) begin
        #(BIT_NS * 1.5);
        for (int i = 0; i < 8; i++) begin
            got[i] = tx_line;
            #BIT_NS;
        end
        got_valid = ~got_valid;
    end
endmodule
`default_nettype wire

// ===== hw/rsu_fifo_if.sv
/*
 * Interface between the port logic and its receive character store.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface rsu_fifo_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic pop;
    logic [WIDTH-1:0] head_data;
    logic [$clog2(DEPTH):0] count;

    modport owner (output push, output push_data, output pop, input head_data, input count);
    modport store (input push, input push_data, input pop, output head_data, output count);
endinterface

`default_nettype wire

// ===== hw/rsu_pkg.sv
/*
 * Constants shared by the serial port block: register offsets, field
 * positions, reset values, cause codes and baud timing figures.
 * Assumes a single 200 MHz system clock drives every file that uses it.
 */
`default_nettype none

package rsu_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte window, three address bits)
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_DIV_HIGH = 3'h1;
    localparam logic [2:0] OFF_CAUSE = 3'h2;
    localparam logic [2:0] OFF_LINE_FORMAT = 3'h3;
    localparam logic [2:0] OFF_MODEM_OUT = 3'h4;
    localparam logic [2:0] OFF_LINE_STATUS = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LF_LEN_LSB = 0;
    localparam int LF_STOP_BIT = 2;
    localparam int LF_PAR_EN_BIT = 3;
    localparam int LF_PAR_EVEN_BIT = 4;
    localparam int LF_PAR_STICK_BIT = 5;
    localparam int LF_BREAK_BIT = 6;
    localparam int LF_DIV_ACCESS_BIT = 7;
    localparam int MO_RTS_BIT = 1;
    localparam int MO_GATE_BIT = 3;
    localparam int LS_READY_BIT = 0;
    localparam int LS_OVERRUN_BIT = 1;
    localparam int LS_PARITY_BIT = 2;
    localparam int LS_FRAMING_BIT = 3;
    localparam int LS_HOLD_EMPTY_BIT = 5;
    localparam int LS_TX_IDLE_BIT = 6;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] LINE_FORMAT_RESET = 8'h00;
    localparam logic [7:0] MODEM_OUT_RESET = 8'h00;
    localparam logic [15:0] DIVISOR_RESET = 16'h000c;
    localparam logic [7:0] CAUSE_NONE = 8'h01;
    localparam logic [7:0] CAUSE_RX_DATA = 8'h04;
    localparam logic [2:0] MIN_DATA_BITS = 3'h5;

    // ------------------------------------------------------------
    // Baud timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 200000000;
    localparam int CRYSTAL_HZ = 3686400;
    localparam int CRYSTAL_DIV = 2;
    localparam int CORE_HZ = CRYSTAL_HZ / CRYSTAL_DIV;
    localparam int OVERSAMPLE = 16;
    localparam int RATE_DIV = CRYSTAL_DIV * OVERSAMPLE;
    localparam int CORE_GAP_MIN = CLOCK_HZ / CORE_HZ;

endpackage

`default_nettype wire

// ===== hw/rsu_rx_store.sv
/*
 * Receive character store: a small circular memory, oldest first.
 * Assumes the owner never pushes when full nor pops when empty.
 * Head data come from a register and lag a push or pop by one clock.
 */
`default_nettype none

module rsu_rx_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    rsu_fifo_if.store fifo
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [WIDTH-1:0] head_q;

    always_ff @(posedge clock) begin
        if (fifo.push) begin
            mem[wr_ptr_q] <= fifo.push_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (fifo.push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (fifo.pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(fifo.push) - (AW+1)'(fifo.pop);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            head_q <= '0;
        end else begin
            head_q <= mem[rd_ptr_q];
        end
    end

    assign fifo.head_data = head_q;
    assign fifo.count = count_q;
endmodule

`default_nettype wire

// ===== hw/rsu_serial_port.sv
/*
 * One asynchronous serial port with its byte register window and
 * transceiver direction control.
 * Assumes the host strobes are synchronous to clock and one cycle long;
 * the line input and the auto-direction jumper are asynchronous.
 */
// Function
// - Line bit 7 swaps data slots for divisor
// - Divisor low at zero, high at one
// - Bit rate is input clock over 32 times divisor
// - Core clock is oscillator halved
// - Two low bits give length minus five
// - Bit 2 selects one or two stops
// - Bits 3 to 6 parity and break
// - Modem bit 1 drives direction output
// - Auto mode driver enable ignores request-to-send bit
// - Modem bit 3 gates interrupt request
// - Status bit 0 shows waiting data
// - Cause register reports data or none
// - Status bit 5 shows holding empty
// - Auto mode drives line while sending
`default_nettype none

module rsu_serial_port #(
    parameter int RX_DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [2:0] address,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [7:0] write_data,
    output logic [7:0] read_data,
    input wire logic rx_line,
    output logic tx_line,
    output logic driver_enable,
    output logic request_to_send,
    output logic interrupt_request,
    input wire logic auto_direction
);
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} rsu_tx_state_type;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rsu_rx_state_type;

    rsu_fifo_if #(.WIDTH(8), .DEPTH(RX_DEPTH)) fifo ();
    rsu_rx_store #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_store (.clock(clock), .reset_n(reset_n), .fifo(fifo));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rsu_mask(input logic [7:0] d, input logic [1:0] len);
        rsu_mask = d & (8'hff >> (2'h3 - len));
    endfunction

    function automatic logic rsu_parity(input logic [7:0] d, input logic [7:0] fmt);
        if (fmt[rsu_pkg::LF_PAR_STICK_BIT]) begin
            rsu_parity = ~fmt[rsu_pkg::LF_PAR_EVEN_BIT];
        end else begin
            rsu_parity = (^rsu_mask(d, fmt[1:0])) ^ ~fmt[rsu_pkg::LF_PAR_EVEN_BIT];
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rx_sync_q;
    logic [1:0] auto_sync_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_sync_q <= 2'h3;
            auto_sync_q <= 2'h0;
        end else begin
            rx_sync_q <= {rx_sync_q[0], rx_line};
            auto_sync_q <= {auto_sync_q[0], auto_direction};
        end
    end
    wire logic rx_s = rx_sync_q[1];
    wire logic auto_s = auto_sync_q[1];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] format_q;
    logic [7:0] modem_q;
    logic [15:0] divisor_q;
    logic [7:0] hold_q;
    logic hold_full_q;
    logic tx_busy;
    logic tx_load;
    logic [2:0] err_set;
    logic [2:0] err_q;
    wire logic div_sel = format_q[rsu_pkg::LF_DIV_ACCESS_BIT];
    wire logic wr_data_slot = write_strobe && address == rsu_pkg::OFF_DATA;
    wire logic rd_data_slot = read_strobe && address == rsu_pkg::OFF_DATA;
    wire logic rx_ready = fifo.count != '0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            format_q <= rsu_pkg::LINE_FORMAT_RESET;
            modem_q <= rsu_pkg::MODEM_OUT_RESET;
            divisor_q <= rsu_pkg::DIVISOR_RESET;
        end else if (write_strobe) begin
            if (address == rsu_pkg::OFF_DATA && div_sel) begin
                divisor_q[7:0] <= write_data;
            end else if (address == rsu_pkg::OFF_DIV_HIGH && div_sel) begin
                divisor_q[15:8] <= write_data;
            end else if (address == rsu_pkg::OFF_LINE_FORMAT) begin
                format_q <= write_data;
            end else if (address == rsu_pkg::OFF_MODEM_OUT) begin
                modem_q <= write_data;
            end
        end
    end

    // Holding register; a write while full overwrites, as host must poll first
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= 8'h00;
            hold_full_q <= 1'b0;
        end else if (wr_data_slot && !div_sel) begin
            hold_q <= write_data;
            hold_full_q <= 1'b1;
        end else if (tx_load) begin
            hold_full_q <= 1'b0;
        end
    end

    // Error flags clear on status read; a new error in that cycle wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            err_q <= 3'h0;
        end else if (read_strobe && address == rsu_pkg::OFF_LINE_STATUS) begin
            err_q <= err_set;
        end else begin
            err_q <= err_q | err_set;
        end
    end

    logic [7:0] status;
    logic [7:0] cause;
    always_comb begin
        status = 8'h00;
        status[rsu_pkg::LS_READY_BIT] = rx_ready;
        status[rsu_pkg::LS_OVERRUN_BIT] = err_q[0];
        status[rsu_pkg::LS_PARITY_BIT] = err_q[1];
        status[rsu_pkg::LS_FRAMING_BIT] = err_q[2];
        status[rsu_pkg::LS_HOLD_EMPTY_BIT] = !hold_full_q;
        status[rsu_pkg::LS_TX_IDLE_BIT] = !hold_full_q && !tx_busy;
        cause = rx_ready ? rsu_pkg::CAUSE_RX_DATA : rsu_pkg::CAUSE_NONE;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= 8'h00;
        end else if (read_strobe) begin
            if (address == rsu_pkg::OFF_DATA) begin
                // Empty store reads zero rather than never-written memory
                read_data <= div_sel ? divisor_q[7:0] : (rx_ready ? fifo.head_data : 8'h00);
            end else if (address == rsu_pkg::OFF_DIV_HIGH) begin
                read_data <= div_sel ? divisor_q[15:8] : 8'h00;
            end else if (address == rsu_pkg::OFF_CAUSE) begin
                read_data <= cause;
            end else if (address == rsu_pkg::OFF_LINE_FORMAT) begin
                read_data <= format_q;
            end else if (address == rsu_pkg::OFF_MODEM_OUT) begin
                read_data <= modem_q;
            end else if (address == rsu_pkg::OFF_LINE_STATUS) begin
                read_data <= status;
            end else begin
                read_data <= 8'h00;
            end
        end
    end

    // Empty pop is ignored, so the two flush reads are always safe
    assign fifo.pop = rd_data_slot && !div_sel && rx_ready;

    // ------------------------------------------------------------
    // Baud generation
    // ------------------------------------------------------------
    // Phase accumulator stands in for the halved oscillator
    logic [31:0] phase_q;
    logic core_tick_q;
    logic [15:0] div_cnt_q;
    logic os_tick_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 32'h0;
            core_tick_q <= 1'b0;
        end else if (phase_q + 32'(rsu_pkg::CORE_HZ) >= 32'(rsu_pkg::CLOCK_HZ)) begin
            phase_q <= phase_q + 32'(rsu_pkg::CORE_HZ) - 32'(rsu_pkg::CLOCK_HZ);
            core_tick_q <= 1'b1;
        end else begin
            phase_q <= phase_q + 32'(rsu_pkg::CORE_HZ);
            core_tick_q <= 1'b0;
        end
    end

    // Divisor zero wraps the full 16 bits, the slowest rate
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_q <= 16'h0;
            os_tick_q <= 1'b0;
        end else begin
            os_tick_q <= 1'b0;
            if (core_tick_q) begin
                if (div_cnt_q >= divisor_q - 16'h1) begin
                    div_cnt_q <= 16'h0;
                    os_tick_q <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 16'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    rsu_tx_state_type tx_state_q;
    logic [7:0] tx_shift_q;
    logic [3:0] tx_os_q;
    logic [2:0] tx_bit_q;
    logic tx_stop_q;
    logic tx_out_q;
    logic tx_par_q;
    wire logic tx_bit_end = os_tick_q && tx_os_q == 4'(rsu_pkg::OVERSAMPLE - 1);
    wire logic [2:0] last_bit = 3'(format_q[1:0]) + rsu_pkg::MIN_DATA_BITS - 3'h1;
    assign tx_load = tx_state_q == TX_IDLE && hold_full_q;
    assign tx_busy = tx_state_q != TX_IDLE;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_q <= TX_IDLE;
            tx_shift_q <= 8'h00;
            tx_os_q <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_stop_q <= 1'b0;
            tx_out_q <= 1'b1;
            tx_par_q <= 1'b0;
        end else begin
            if (os_tick_q) begin
                tx_os_q <= tx_os_q + 4'h1;
            end
            case (tx_state_q)
                TX_IDLE: begin
                    tx_out_q <= 1'b1;
                    if (hold_full_q) begin
                        tx_shift_q <= hold_q;
                        tx_par_q <= rsu_parity(hold_q, format_q);
                        tx_os_q <= 4'h0;
                        tx_out_q <= 1'b0;
                        tx_state_q <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_out_q <= tx_shift_q[0];
                        tx_bit_q <= 3'h0;
                        tx_state_q <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_bit_q <= tx_bit_q + 3'h1;
                        tx_out_q <= tx_shift_q[1];
                        if (tx_bit_q == last_bit) begin
                            tx_out_q <= format_q[rsu_pkg::LF_PAR_EN_BIT] ? tx_par_q : 1'b1;
                            tx_stop_q <= format_q[rsu_pkg::LF_STOP_BIT];
                            tx_state_q <= format_q[rsu_pkg::LF_PAR_EN_BIT] ? TX_PARITY : TX_STOP;
                        end
                    end
                end
                TX_PARITY: begin
                    if (tx_bit_end) begin
                        tx_out_q <= 1'b1;
                        tx_state_q <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_bit_end) begin
                        tx_stop_q <= 1'b0;
                        if (!tx_stop_q) begin
                            tx_state_q <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // Break holds the line low whatever the engine does
    assign tx_line = tx_out_q && !format_q[rsu_pkg::LF_BREAK_BIT];

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    rsu_rx_state_type rx_state_q;
    logic [7:0] rx_shift_q;
    logic [3:0] rx_os_q;
    logic [2:0] rx_bit_q;
    logic rx_par_q;
    logic push_q;
    logic [7:0] push_data_q;
    wire logic rx_mid = os_tick_q && rx_os_q == 4'(rsu_pkg::OVERSAMPLE / 2 - 1);
    wire logic rx_full = fifo.count >= ($clog2(RX_DEPTH) + 1)'(RX_DEPTH);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_q <= RX_IDLE;
            rx_shift_q <= 8'h00;
            rx_os_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_par_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= 8'h00;
            err_set <= 3'h0;
        end else begin
            push_q <= 1'b0;
            err_set <= 3'h0;
            if (os_tick_q) begin
                rx_os_q <= rx_os_q + 4'h1;
            end
            case (rx_state_q)
                RX_IDLE: begin
                    rx_os_q <= 4'h0;
                    if (!rx_s) begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid) begin
                        rx_bit_q <= 3'h0;
                        rx_state_q <= rx_s ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        rx_shift_q <= {rx_s, rx_shift_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == last_bit) begin
                            rx_state_q <= format_q[rsu_pkg::LF_PAR_EN_BIT] ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_mid) begin
                        rx_par_q <= rx_s;
                        rx_state_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_mid) begin
                        push_data_q <= rx_shift_q >> (3'h3 - format_q[1:0]);
                        push_q <= !rx_full;
                        err_set[0] <= rx_full;
                        err_set[1] <= format_q[rsu_pkg::LF_PAR_EN_BIT]
                            && rx_par_q != rsu_parity(rx_shift_q >> (3'h3 - format_q[1:0]), format_q);
                        err_set[2] <= !rx_s;
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    assign fifo.push = push_q;
    assign fifo.push_data = push_data_q;

    // ------------------------------------------------------------
    // Direction and interrupt outputs
    // ------------------------------------------------------------
    assign request_to_send = modem_q[rsu_pkg::MO_RTS_BIT];
    // Auto mode keys the driver while anything waits or shifts
    assign driver_enable = auto_s ? (hold_full_q || tx_busy) : modem_q[rsu_pkg::MO_RTS_BIT];
    assign interrupt_request = modem_q[rsu_pkg::MO_GATE_BIT] && rx_ready;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic [7:0] gap_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= 8'h0;
        end else begin
            gap_q <= core_tick_q ? 8'h0 : gap_q + 8'h1;
        end
    end

    divisor_read_a: assert property (read_strobe && address == rsu_pkg::OFF_DATA && div_sel
        |=> read_data == $past(divisor_q[7:0])) else $error("divisor low not read back");
    divisor_high_a: assert property (write_strobe && address == rsu_pkg::OFF_DIV_HIGH && div_sel
        |=> divisor_q[15:8] == $past(write_data)) else $error("divisor high not latched");
    core_gap_a: assert property ($rose(core_tick_q) && $past(gap_q) > 8'h0
        |-> $past(gap_q) >= 8'(rsu_pkg::CORE_GAP_MIN - 2)) else $error("core tick too fast");
    ready_flag_a: assert property (push_q && !fifo.pop |=> status[rsu_pkg::LS_READY_BIT])
        else $error("data ready missing after push");
    hold_empty_a: assert property (wr_data_slot && !div_sel |=> !status[rsu_pkg::LS_HOLD_EMPTY_BIT])
        else $error("holding empty after write");
    cause_code_a: assert property (fifo.count == '0 |-> cause == rsu_pkg::CAUSE_NONE)
        else $error("cause not none when empty");
    auto_drive_a: assert property (auto_s && tx_state_q == TX_START |-> driver_enable)
        else $error("driver off while sending");
    irq_gate_a: assert property (!modem_q[rsu_pkg::MO_GATE_BIT] |-> !interrupt_request)
        else $error("interrupt passed closed gate");
    pop_clear_a: assert property (fifo.pop && fifo.count == 1 && !push_q
        |=> !status[rsu_pkg::LS_READY_BIT]) else $error("ready stuck after last read");
    start_len_a: assert property ($rose(tx_state_q == TX_DATA) |-> tx_line == $past(tx_shift_q[0])
        || format_q[rsu_pkg::LF_BREAK_BIT]) else $error("first data bit wrong");
endmodule

`default_nettype wire
